// ---- rtl/psm_ctrl.sv ----
`timescale 1ns/1ps
// Function
// - halt flag stops oscillator, clocks, timers
// - idle flag keeps oscillator, supervisor, idle timer
// - low power freezes all state except idle timer
// - halt inhibits supervisor; clock monitor faults output
// - halt exits on port l, clock-out rise (rc option only), reset
// - crystal wakeup: oscillator, load 256, count
// - instruction clock is oscillator divided by ten
// - rc delay only when delay bit set
// - halt-disable option: halt flag stays zero
// - idle exits on reset, port l, bit-13 toggle
// - bit-13 toggle sets idle tick pending flag
// - idle tick interrupt only when enable set
// - enabled idle wake runs service routine first
// - disabled idle wake resumes at next instruction
// - idle timer: 16-bit hidden free-running down-counter
// - halt refused while port l wakeup pending
module psm_ctrl #(
   parameter bit HALT_DISABLE = 1'b0,   // mask option: halt mode disabled
   parameter bit CLK_CRYSTAL  = 1'b1    // clock option: crystal/resonator, else rc
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst,
   input  wire logic                         i_ce,
   input  wire logic                         i_port_g_wr,
   input  wire logic                         i_port_g_bit_seven,
   input  wire logic                         i_port_g_bit_six,
   input  wire logic                         i_cfg_wr,
   input  wire logic                         i_rc_startup_delay_enable,
   input  wire logic                         i_irq_en_wr,
   input  wire logic                         i_idle_tick_irq_enable,
   input  wire logic                         i_idle_tick_pending_clr,
   input  wire logic [psm_pkg::PORT_L_W-1:0] i_port_l_wakeup_en,
   input  wire logic [psm_pkg::PORT_L_W-1:0] i_port_l_wakeup_pnd,
   input  wire logic                         i_clock_out_pin,
   input  wire logic                         i_clkmon_en,
   output logic                              o_halt_flag,
   output logic                              o_idle_flag,
   output logic                              o_osc_run,
   output logic                              o_logic_clk_en,
   output logic                              o_exec_en,
   output logic                              o_state_hold,
   output logic                              o_supervisor_detect_en,
   output logic                              o_supervisor_fault_out_n,
   output logic                              o_rc_startup_delay_enable,
   output logic                              o_idle_tick_pending,
   output logic                              o_idle_tick_irq_enable,
   output logic                              o_idle_tick_irq,
   output logic                              o_resume,
   output logic                              o_resume_to_isr
);
   // ----------------------------------------------------------------
   // idle timer
   // ----------------------------------------------------------------
   psm_tmr_if tmr ();

   psm_idle_timer #(
      .W (psm_pkg::TMR_W)
   ) u_timer (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .t     (tmr.tmr)
   );

   // ----------------------------------------------------------------
   // clock-out pin synchroniser and rising edge
   // ----------------------------------------------------------------
   logic cko_s1_q;
   logic cko_s2_q;
   logic cko_prev_q;
   logic cko_rise;

   // the pin is asynchronous; two flops before any decode
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cko_s1_q   <= 1'b0;
         cko_s2_q   <= 1'b0;
         cko_prev_q <= 1'b0;
      end else if (i_ce) begin
         cko_s1_q   <= i_clock_out_pin;
         cko_s2_q   <= cko_s1_q;
         cko_prev_q <= cko_s2_q;
      end
   end

   // crystal builds make the pin a dedicated output, so its edge is ignored
   assign cko_rise = !CLK_CRYSTAL && cko_s2_q && !cko_prev_q;

   // ----------------------------------------------------------------
   // request and wake decode
   // ----------------------------------------------------------------
   psm_pkg::psm_state_t state_q;
   psm_pkg::psm_state_t state_d;
   logic                wake_l;
   logic                halt_req;
   logic                idle_req;
   logic                dly_en_q;
   logic                dly_en_d;
   logic                use_delay;
   logic                halt_wake;
   logic                idle_wake;
   logic                pnd_q;
   logic                pnd_d;
   logic                irq_en_q;
   logic                irq_en_d;

   assign wake_l    = |(i_port_l_wakeup_en & i_port_l_wakeup_pnd);
   // pending enabled port l bits block halt entry; mask option blocks it too
   assign halt_req  = i_port_g_wr && i_port_g_bit_seven && !HALT_DISABLE && !wake_l;
   assign idle_req  = i_port_g_wr && i_port_g_bit_six && !halt_req;
   assign halt_wake = wake_l || cko_rise;
   assign idle_wake = wake_l || tmr.tgl13;
   // crystal always waits for the oscillator; rc only when asked to
   assign use_delay = CLK_CRYSTAL || dly_en_q;
   assign dly_en_d  = i_cfg_wr ? i_rc_startup_delay_enable : dly_en_q;
   assign irq_en_d  = i_irq_en_wr ? i_idle_tick_irq_enable : irq_en_q;
   // a toggle in the same cycle as a clear wins
   assign pnd_d     = tmr.tgl13 || (pnd_q && !i_idle_tick_pending_clr);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         psm_pkg::PSM_RUN: begin
            if (halt_req) begin
               state_d = psm_pkg::PSM_HALT;
            end else if (idle_req) begin
               state_d = psm_pkg::PSM_IDLE;
            end
         end
         psm_pkg::PSM_HALT: begin
            if (halt_wake) begin
               state_d = use_delay ? psm_pkg::PSM_START : psm_pkg::PSM_RUN;
            end
         end
         psm_pkg::PSM_START: begin
            if (tmr.zero) begin
               state_d = psm_pkg::PSM_RUN;
            end
         end
         psm_pkg::PSM_IDLE: begin
            if (idle_wake) begin
               state_d = psm_pkg::PSM_RUN;
            end
         end
      endcase
   end

   // timer clock follows the oscillator: stopped only in halt
   assign tmr.ce   = i_ce;
   assign tmr.run  = (state_q != psm_pkg::PSM_HALT);
   assign tmr.load = (state_q == psm_pkg::PSM_HALT) && halt_wake && use_delay;

   // state and flags
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q  <= psm_pkg::PSM_RUN;
         dly_en_q <= psm_pkg::DLY_EN_RST;
         pnd_q    <= psm_pkg::PND_RST;
         irq_en_q <= psm_pkg::IRQ_EN_RST;
      end else if (i_ce) begin
         state_q  <= state_d;
         dly_en_q <= dly_en_d;
         pnd_q    <= pnd_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs, decoded from the next state
   // ----------------------------------------------------------------
   logic run_d;
   logic halt_d;
   logic resume_d;

   assign run_d    = (state_d == psm_pkg::PSM_RUN);
   assign halt_d   = (state_d == psm_pkg::PSM_HALT);
   assign resume_d = run_d && (state_q != psm_pkg::PSM_RUN);

   // everything but the idle timer freezes outside run, so state is kept
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_halt_flag               <= 1'b0;
         o_idle_flag               <= 1'b0;
         o_osc_run                 <= 1'b1;
         o_logic_clk_en            <= 1'b1;
         o_exec_en                 <= 1'b1;
         o_state_hold              <= 1'b0;
         o_supervisor_detect_en    <= 1'b1;
         o_supervisor_fault_out_n  <= 1'b1;
         o_rc_startup_delay_enable <= psm_pkg::DLY_EN_RST;
         o_idle_tick_pending       <= psm_pkg::PND_RST;
         o_idle_tick_irq_enable    <= psm_pkg::IRQ_EN_RST;
         o_idle_tick_irq           <= 1'b0;
         o_resume                  <= 1'b0;
         o_resume_to_isr           <= 1'b0;
      end else if (i_ce) begin
         o_halt_flag               <= halt_d || (state_d == psm_pkg::PSM_START);
         o_idle_flag               <= (state_d == psm_pkg::PSM_IDLE);
         o_osc_run                 <= !halt_d;
         o_logic_clk_en            <= run_d;
         o_exec_en                 <= run_d;
         o_state_hold              <= !run_d;
         o_supervisor_detect_en    <= run_d || (state_d == psm_pkg::PSM_IDLE);
         // stopped oscillator seen by an enabled clock monitor pulls the pin low
         o_supervisor_fault_out_n  <= !(halt_d && i_clkmon_en);
         o_rc_startup_delay_enable <= dly_en_d;
         o_idle_tick_pending       <= pnd_d;
         o_idle_tick_irq_enable    <= irq_en_d;
         o_idle_tick_irq           <= pnd_d && irq_en_d;
         o_resume                  <= resume_d;
         o_resume_to_isr           <= resume_d && pnd_d && irq_en_d;
      end else begin
         o_resume                  <= 1'b0;
         o_resume_to_isr           <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_halt_entry;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_RUN && halt_req) |=> o_halt_flag && !o_osc_run && !o_exec_en;
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt entry did not stop clocks");

   property p_idle_entry;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_RUN && idle_req) |=> o_osc_run && !o_exec_en && o_supervisor_detect_en;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong clocks");

   property p_halt_fault;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && halt_d && i_clkmon_en) |=> !o_supervisor_fault_out_n && !o_supervisor_detect_en;
   endproperty
   a_halt_fault: assert property (p_halt_fault) else $error("clock monitor fault missing in halt");

   property p_halt_disabled;
      @(posedge i_clk) disable iff (i_rst)
      HALT_DISABLE |-> !o_halt_flag;
   endproperty
   a_halt_disabled: assert property (p_halt_disabled) else $error("halt flag set with halt disabled");

   property p_halt_refused;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_RUN && wake_l) |=> !o_halt_flag;
   endproperty
   a_halt_refused: assert property (p_halt_refused) else $error("halt entered with wakeup pending");

   property p_idle_exit;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_IDLE && tmr.tgl13) |=> o_exec_en && o_resume && o_idle_tick_pending;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle did not end on timer toggle");

   property p_pnd_set;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && tmr.tgl13 && i_idle_tick_pending_clr) |=> o_idle_tick_pending;
   endproperty
   a_pnd_set: assert property (p_pnd_set) else $error("toggle lost against clear");

   property p_irq_gate;
      @(posedge i_clk) disable iff (i_rst)
      o_idle_tick_irq |-> o_idle_tick_pending && o_idle_tick_irq_enable;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

   property p_start_done;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_START && tmr.zero) |=> o_exec_en && !o_halt_flag && o_resume;
   endproperty
   a_start_done: assert property (p_start_done) else $error("no resume after start-up delay");

   property p_rc_nodelay;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_q == psm_pkg::PSM_HALT && halt_wake && !use_delay) |=> o_exec_en;
   endproperty
   a_rc_nodelay: assert property (p_rc_nodelay) else $error("rc wake delayed with delay bit clear");

   c_halt_wake: cover property (@(posedge i_clk) disable iff (i_rst) state_q == psm_pkg::PSM_START ##1 o_resume);
   c_idle_isr: cover property (@(posedge i_clk) disable iff (i_rst) o_resume_to_isr);
   c_idle_l: cover property (@(posedge i_clk) disable iff (i_rst) state_q == psm_pkg::PSM_IDLE && wake_l);
endmodule

// ---- rtl/psm_pkg.sv ----
package psm_pkg;
   // ----------------------------------------------------------------
   // clocking and idle timer
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;                 // oscillator clock, 50 MHz
   localparam int unsigned TC_DIV        = 10;                 // instruction clock = oscillator / 10
   localparam int unsigned PRE_W         = 4;                  // prescaler width for the divide
   localparam logic [3:0]  PRE_LAST      = 4'(TC_DIV - 1);     // last prescaler count before a tick
   localparam logic [3:0]  PRE_RST       = 4'h0;
   localparam int unsigned TMR_W         = 16;                 // idle timer width
   localparam logic [15:0] START_DLY     = 16'h0100;           // 256 instruction cycles of start-up
   localparam logic [15:0] TMR_RST       = 16'hFFFF;           // idle timer value after reset
   localparam int unsigned TGL_BIT       = 13;                 // idle timer bit whose toggle wakes idle
   localparam int unsigned PORT_L_W      = 8;                  // port l wakeup lines

   // ----------------------------------------------------------------
   // reset values of control bits
   // ----------------------------------------------------------------
   localparam logic DLY_EN_RST  = 1'b0;
   localparam logic IRQ_EN_RST  = 1'b0;
   localparam logic PND_RST     = 1'b0;

   // gray order along run -> halt -> start-up; idle hangs off run
   typedef enum logic [1:0] {
      PSM_RUN   = 2'b00,
      PSM_HALT  = 2'b01,
      PSM_START = 2'b11,
      PSM_IDLE  = 2'b10
   } psm_state_t;
endpackage

// ---- rtl/psm_tmr_if.sv ----
`timescale 1ns/1ps
// control and status between the sequencer and its idle timer
interface psm_tmr_if;
   logic ce;     // global clock enable
   logic run;    // timer clock present (oscillator running)
   logic load;   // load the start-up delay
   logic tgl13;  // one-cycle pulse: watched bit toggled
   logic zero;   // counter stands at zero

   modport ctrl (output ce, output run, output load, input tgl13, input zero);
   modport tmr  (input ce, input run, input load, output tgl13, output zero);
endinterface

// ---- rtl/psm_idle_timer.sv ----
`timescale 1ns/1ps
module psm_idle_timer #(
   parameter int unsigned W = psm_pkg::TMR_W
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   psm_tmr_if.tmr    t
);
   // ----------------------------------------------------------------
   // prescaler and down-counter
   // ----------------------------------------------------------------
   logic [psm_pkg::PRE_W-1:0] pre_q;
   logic [W-1:0]              cnt_q;
   logic [W-1:0]              cnt_dec;
   logic                      tick;

   // one instruction-cycle tick every ten oscillator clocks
   assign tick    = t.ce && t.run && !t.load && (pre_q == psm_pkg::PRE_LAST);
   assign cnt_dec = cnt_q - W'(1);
   assign t.tgl13 = tick && (cnt_q[psm_pkg::TGL_BIT] != cnt_dec[psm_pkg::TGL_BIT]);
   assign t.zero  = (cnt_q == '0);

   // counter free-runs whenever the oscillator does; software has no access
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_q <= psm_pkg::PRE_RST;
         cnt_q <= W'(psm_pkg::TMR_RST);
      end else if (t.ce) begin
         if (t.load) begin
            pre_q <= psm_pkg::PRE_RST;                 // restart divide so the delay is exact
            cnt_q <= W'(psm_pkg::START_DLY);
         end else if (t.run) begin
            pre_q <= tick ? psm_pkg::PRE_RST : pre_q + 4'h1;
            if (tick) begin
               cnt_q <= cnt_dec;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_load_delay;
      @(posedge i_clk) disable iff (i_rst)
      (t.ce && t.load) |=> (cnt_q == W'(psm_pkg::START_DLY)) && (pre_q == psm_pkg::PRE_RST);
   endproperty
   a_load_delay: assert property (p_load_delay) else $error("start-up delay not loaded");

   // cycles since the last tick, held at the divide's last count; a counter keeps
   // the ten-cycle spacing check cheap instead of unrolling a long repetition
   logic [psm_pkg::PRE_W-1:0] gap_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_q <= psm_pkg::PRE_LAST;
      end else if (t.ce) begin
         if (tick) begin
            gap_q <= psm_pkg::PRE_RST;
         end else if (gap_q != psm_pkg::PRE_LAST) begin
            gap_q <= gap_q + 4'h1;
         end
      end
   end

   property p_tick_div;
      @(posedge i_clk) disable iff (i_rst)
      tick |-> (gap_q == psm_pkg::PRE_LAST);
   endproperty
   a_tick_div: assert property (p_tick_div) else $error("instruction tick faster than divide");

   property p_hold_when_stopped;
      @(posedge i_clk) disable iff (i_rst)
      (!t.run && !t.load) |=> $stable(cnt_q);
   endproperty
   a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("timer moved without clock");

   c_tgl: cover property (@(posedge i_clk) disable iff (i_rst) t.tgl13);
endmodule

// ---- verif/psm_far_model.sv ----
`timescale 1ns/1ps
// far side of the sequencer: port l wakeup lines, clock-out pin, clock monitor enable
module psm_far_model (
   input  wire logic                         i_clk,
   output logic [psm_pkg::PORT_L_W-1:0]      o_wk_en,
   output logic [psm_pkg::PORT_L_W-1:0]      o_wk_pnd,
   output logic                              o_cko,
   output logic                              o_clkmon_en
);
   // idle levels at time zero; the monitor starts enabled, as after a chip reset
   initial begin
      o_wk_en     = 8'h00;
      o_wk_pnd    = 8'h00;
      o_cko       = 1'b0;
      o_clkmon_en = 1'b1;
   end

   // a latched wakeup edge stays pending until software clears it
   task automatic wake_l(input logic [psm_pkg::PORT_L_W-1:0] m);
      @(posedge i_clk);
      #1 o_wk_en = m;
      o_wk_pnd = m;
   endtask

   task automatic clear_l();
      @(posedge i_clk);
      #1 o_wk_pnd = 8'h00;
      o_wk_en = 8'h00;
   endtask

   // clock-out edge is only a wake source with the rc clock option
   task automatic set_cko(input logic v);
      @(posedge i_clk);
      #1 o_cko = v;
   endtask

   // software drops the monitor so a deliberate halt does not fault
   task automatic set_mon(input logic v);
      @(posedge i_clk);
      #1 o_clkmon_en = v;
   endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic                         i_clk = 1'b0;
   logic                         i_rst = 1'b1;
   logic [2:0]                   wr    = 3'h0;
   logic                         b7    = 1'b0;
   logic                         b6    = 1'b0;
   logic                         ce    = 1'b1;
   logic                         cfg_wr = 1'b0, en_wr = 1'b0, pnd_clr = 1'b0, dat = 1'b0;
   logic [psm_pkg::PORT_L_W-1:0] wk_en, wk_pnd;
   logic                         clock_out_pin, mon;
   logic [2:0]                   halt, idle, osc, clk_en, exec, hold, det, flt_n, cfg, pnd, irq_en, irq, res, isr;
   int                           mismatches = 0;
   int                           n_tests = 0;
   int                           n = 0;

   always #10 i_clk = ~i_clk;

   psm_far_model far (.i_clk, .o_wk_en(wk_en), .o_wk_pnd(wk_pnd), .o_cko(clock_out_pin), .o_clkmon_en(mon));

   // 0: crystal, 1: rc clock option; inputs shared, port g write strobes separate
   for (genvar g = 0; g < 2; g++) begin : u
      psm_ctrl #(.CLK_CRYSTAL(g == 0)) uut (
         .i_clk, .i_rst, .i_ce(ce), .i_port_g_wr(wr[g]), .i_port_g_bit_seven(b7), .i_port_g_bit_six(b6),
         .i_cfg_wr(cfg_wr), .i_rc_startup_delay_enable(dat), .i_irq_en_wr(en_wr), .i_idle_tick_irq_enable(dat),
         .i_idle_tick_pending_clr(pnd_clr), .i_port_l_wakeup_en(wk_en), .i_port_l_wakeup_pnd(wk_pnd),
         .i_clock_out_pin(clock_out_pin), .i_clkmon_en(mon), .o_halt_flag(halt[g]), .o_idle_flag(idle[g]),
         .o_osc_run(osc[g]), .o_logic_clk_en(clk_en[g]), .o_exec_en(exec[g]), .o_state_hold(hold[g]),
         .o_supervisor_detect_en(det[g]), .o_supervisor_fault_out_n(flt_n[g]),
         .o_rc_startup_delay_enable(cfg[g]), .o_idle_tick_pending(pnd[g]), .o_idle_tick_irq_enable(irq_en[g]),
         .o_idle_tick_irq(irq[g]), .o_resume(res[g]), .o_resume_to_isr(isr[g]));
   end

   // 2: halt masked off, clock option left at its default
   psm_ctrl #(.HALT_DISABLE(1'b1)) uut (
      .i_clk, .i_rst, .i_ce(ce), .i_port_g_wr(wr[2]), .i_port_g_bit_seven(b7), .i_port_g_bit_six(b6),
      .i_cfg_wr(cfg_wr), .i_rc_startup_delay_enable(dat), .i_irq_en_wr(en_wr), .i_idle_tick_irq_enable(dat),
      .i_idle_tick_pending_clr(pnd_clr), .i_port_l_wakeup_en(wk_en), .i_port_l_wakeup_pnd(wk_pnd),
      .i_clock_out_pin(clock_out_pin), .i_clkmon_en(mon), .o_halt_flag(halt[2]), .o_idle_flag(idle[2]),
      .o_osc_run(osc[2]), .o_logic_clk_en(clk_en[2]), .o_exec_en(exec[2]), .o_state_hold(hold[2]),
      .o_supervisor_detect_en(det[2]), .o_supervisor_fault_out_n(flt_n[2]),
      .o_rc_startup_delay_enable(cfg[2]), .o_idle_tick_pending(pnd[2]), .o_idle_tick_irq_enable(irq_en[2]),
      .o_idle_tick_irq(irq[2]), .o_resume(res[2]), .o_resume_to_isr(isr[2]));

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   // port g write to one controller, then two quiet cycles before anything is looked at
   task automatic pg_wr(input int k, input logic h, input logic i);
      @(posedge i_clk);
      #1 wr[k] = 1'b1;
      b7 = h;
      b6 = i;
      @(posedge i_clk);
      #1 wr = 3'h0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   // k = 0 delay config, 1 irq enable, 2 pending clear
   task automatic ctl(input int k, input logic d);
      @(posedge i_clk);
      #1 cfg_wr = (k == 0);
      en_wr = (k == 1);
      pnd_clr = (k == 2);
      dat = d;
      @(posedge i_clk);
      #1 {cfg_wr, en_wr, pnd_clr} = 3'h0;
      @(posedge i_clk);
      #1;
   endtask

   // resume is a one-cycle pulse, so poll every cycle; n counts the cycles waited
   task automatic wait_res(input int k, input int lim);
      n = 0;
      while (res[k] !== 1'b1) begin
         @(posedge i_clk);
         #1 n++;
         if (n > lim) begin
            mismatches++;
            $display("MISMATCH resume wait expected within %0d seen none", lim);
            stop_test();
         end
      end
   endtask

   initial begin
      repeat (10) @(posedge i_clk);
      #1 i_rst = 1'b0;
      @(posedge i_clk);
      #1;
      chk("halt_flag", 1'b0, halt[0]);
      chk("exec_en", 1'b1, exec[0]);
      chk("delay_en", 1'b0, cfg[1]);
      chk("pending", 1'b0, pnd[0]);
      // masked-off halt: the flag never reads one
      pg_wr(2, 1'b1, 1'b0);
      chk("hd halt_flag", 1'b0, halt[2]);
      chk("hd exec_en", 1'b1, exec[2]);
      // idle with tick interrupt on; only the timer toggle can wake it
      ctl(1, 1'b1);
      chk("irq_en", 1'b1, irq_en[0]);
      pg_wr(0, 1'b0, 1'b1);
      chk("idle_flag", 1'b1, idle[0]);
      chk("idle osc_run", 1'b1, osc[0]);
      chk("idle exec_en", 1'b0, exec[0]);
      chk("idle detect_en", 1'b1, det[0]);
      chk("idle hold", 1'b1, hold[0]);
      wait_res(0, 90000);
      chk("toggle time", 1'b1, logic'(n >= 81860 && n <= 81930));
      chk("resume_to_isr", 1'b1, isr[0]);
      @(posedge i_clk);
      #1;
      chk("pending set", 1'b1, pnd[0]);
      chk("tick irq", 1'b1, irq[0]);
      chk("idle left", 1'b0, idle[0]);
      chk("exec after idle", 1'b1, exec[0]);
      ctl(2, 1'b0);
      ctl(1, 1'b0);
      chk("pending clr", 1'b0, pnd[0]);
      chk("irq off", 1'b0, irq[0]);
      // halt refused while an enabled port l bit is pending
      far.wake_l(8'h08);
      pg_wr(0, 1'b1, 1'b0);
      chk("refused halt", 1'b0, halt[0]);
      chk("refused exec", 1'b1, exec[0]);
      far.clear_l();
      // idle, interrupt off, port l wake goes straight back to the next instruction
      pg_wr(0, 1'b0, 1'b1);
      chk("idle again", 1'b1, idle[0]);
      far.wake_l(8'h01);
      wait_res(0, 20);
      chk("no isr", 1'b0, isr[0]);
      far.clear_l();
      // crystal halt with the clock monitor on
      pg_wr(0, 1'b1, 1'b0);
      chk("halt_flag set", 1'b1, halt[0]);
      chk("halt osc_run", 1'b0, osc[0]);
      chk("halt clk_en", 1'b0, clk_en[0]);
      chk("halt hold", 1'b1, hold[0]);
      chk("halt detect_en", 1'b0, det[0]);
      chk("halt fault_n", 1'b0, flt_n[0]);
      far.wake_l(8'h80);
      repeat (3) @(posedge i_clk);
      #1;
      chk("startup osc_run", 1'b1, osc[0]);
      chk("startup exec_en", 1'b0, exec[0]);
      chk("startup halt_flag", 1'b1, halt[0]);
      wait_res(0, 3000);
      chk("startup length", 1'b1, logic'(n + 3 >= 2560 && n + 3 <= 2566));
      chk("resumed exec", 1'b1, exec[0]);
      chk("resumed halt_flag", 1'b0, halt[0]);
      far.clear_l();
      // rc option, monitor off, no delay: clock-out rise wakes quickly
      far.set_mon(1'b0);
      pg_wr(1, 1'b1, 1'b0);
      chk("rc halt_flag", 1'b1, halt[1]);
      chk("rc fault_n", 1'b1, flt_n[1]);
      far.set_cko(1'b1);
      wait_res(1, 8);
      far.set_cko(1'b0);
      // rc option with the delay bit set
      ctl(0, 1'b1);
      chk("delay_en set", 1'b1, cfg[1]);
      pg_wr(1, 1'b1, 1'b0);
      far.set_cko(1'b1);
      wait_res(1, 3000);
      chk("rc delay length", 1'b1, logic'(n >= 2560 && n <= 2570));
      far.set_cko(1'b0);
      // reset pin is the third way out of halt
      pg_wr(0, 1'b1, 1'b0);
      chk("halt before reset", 1'b1, halt[0]);
      i_rst = 1'b1;
      @(posedge i_clk);
      #1 i_rst = 1'b0;
      @(posedge i_clk);
      #1;
      chk("reset halt_flag", 1'b0, halt[0]);
      chk("reset exec_en", 1'b1, exec[0]);
      chk("reset delay_en", 1'b0, cfg[1]);
      // clock enable low: a port g write is not taken and nothing stale applies once it rises
      ce = 1'b0;
      pg_wr(0, 1'b0, 1'b1);
      chk("ce idle_flag", 1'b0, idle[0]);
      chk("ce exec_en", 1'b1, exec[0]);
      ce = 1'b1;
      @(posedge i_clk);
      #1;
      chk("ce released idle_flag", 1'b0, idle[0]);
      stop_test();
   end
endmodule
